// ### common/slem_pkg.sv
// Shared constants and types for the serial link error monitor
`default_nettype none
package slem_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int         ADDR_W        = 12;
  localparam logic [11:0] OFF_LINK_CTL  = 12'h300;
  localparam logic [11:0] OFF_PULSE_CTL = 12'h312;
  localparam logic [11:0] OFF_CNT_SEL   = 12'h46B;
  localparam logic [11:0] OFF_DISP_CTL  = 12'h46D;
  localparam logic [11:0] OFF_TBL_CTL   = 12'h46E;
  localparam logic [11:0] OFF_CCH_CTL   = 12'h46F;
  localparam logic [11:0] OFF_CGS_STAT  = 12'h470;
  localparam logic [11:0] OFF_ALIGN_ST  = 12'h473;
  localparam logic [11:0] OFF_MODE      = 12'h477;
  localparam logic [11:0] OFF_IRQ       = 12'h47A;
  localparam logic [11:0] OFF_MASK      = 12'h47B;
  localparam logic [11:0] OFF_LIMIT     = 12'h47C;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LINK_EN_BIT   = 0;
  localparam int LINK_SEL_BIT  = 2;
  localparam int DUAL_BIT      = 3;
  localparam int PW_LSB        = 4;
  localparam int ILAS_TEST_BIT = 7;
  localparam int TM_EN_BIT     = 3;
  localparam int CNT_LANE_LSB  = 4;
  localparam int CLR_IRQ_BIT   = 7;
  localparam int DIS_BIT       = 6;
  localparam int CLR_CNT_BIT   = 5;
  localparam int TYPE_HI_BIT   = 7;
  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] LINK_CTL_RST  = 8'h00;
  localparam logic [7:0] PULSE_CTL_RST = 8'h00;
  localparam logic [7:0] LIMIT_RST     = 8'hFF;
  localparam logic [7:0] ZERO8         = 8'h00;
  localparam logic [2:0] CGS_NEED      = 3'h4;
  localparam logic [2:0] DISP_REINIT   = 3'h4;
  localparam logic [2:0] LINK1_OFS     = 3'h4;
  localparam int         REINIT_FRAMES = 5;
  localparam int         REINIT_OCTETS = 9;
  // Counter select codes
  localparam logic [1:0] TYPE_DISP = 2'h0;
  localparam logic [1:0] TYPE_TBL  = 2'h1;
  localparam logic [1:0] TYPE_CCH  = 2'h2;
  // Link state
  typedef enum logic [1:0] {
    ST_CGS    = 2'b00,
    ST_RUN    = 2'b01,
    ST_REINIT = 2'b10
  } slem_state_t;
endpackage
`default_nettype wire

// ### verilog/slem_monitor.sv
// Receive-side error counter, threshold and sync request logic
`timescale 1ns/1ps
`default_nettype none
//
// Function
// [R1] ILAS test mode bit lets CGS then repeated ILAS pass.
// [R2] Release sync after four K characters on every enabled lane.
// [R3] Link select bit picks link 0 or link 1 lane status.
// [R4] With link 1 selected, lane index x means lane x plus four.
// [R5] Detect disparity, table miss and control character errors.
// [R6] Count select register picks lane and type; read gives count.
// [R7] Type codes: 00 disparity, 01 table miss, 10 control char.
// [R8] Counters saturate at the programmed error limit.
// [R9] One limit for all types; three over-limit status registers.
// [R10] Bit 7 write clears that type's interrupt for addressed lane.
// [R11] Bit 6 disables counting, bit 5 clears count, per lane.
// [R12] Control register reads return over-limit status.
// [R13] Any error pulses sync low for half, one or two cycles.
// [R14] Software picks width so pulse spans two frames.
// [R15] Over-limit interrupt events enabled and read at same bits.
// [R16] Four bad disparity characters request reinitialization.
// [R17] Reinitialization request lasts five frames plus nine octets.
// [R18] Mask enable allows limit resync; unmasked types never saturate (code: only while TM_EN_BIT of mode is set, else all types saturate).
// [R19] Mask bits 7,6,5 let each type trigger a sync request.
// [R20] Masked-in type reaching limit on any lane drops sync.
// [R21] Reinitialization clears counters but keeps interrupt status.
// [R22] Software reads alignment status after ILAS test.
// [R23] Alignment status bit x high when lane x passed alignment.
// [R24] Counter increments per erroneous character while enabled.
// [R25] Sync request is active low; error report is a low pulse.
module slem_monitor #(
  parameter int LANES            = 8,
  parameter int OCTETS_PER_FRAME = 1,
  parameter int OCTETS_PER_PCLK  = 4
) (
  // Clock and reset
  input  wire logic                      mclk_in,
  input  wire logic                      sys_rst_in,
  // Register port
  input  wire logic [slem_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]                reg_wdata_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  output logic      [7:0]                reg_rdata_out,
  // Decoder events, one bit per lane
  input  wire logic [LANES-1:0]          disp_err_in,
  input  wire logic [LANES-1:0]          table_miss_in,
  input  wire logic [LANES-1:0]          ctrl_char_err_in,
  input  wire logic [LANES-1:0]          k_char_in,
  input  wire logic [LANES-1:0]          lane_aligned_in,
  input  wire logic [LANES-1:0]          lane_enable_in,
  // Processing clock from the link side
  input  wire logic                      processing_clock_in,
  // Sync request, active low
  output logic                           sync_request_out
);
  localparam int RE_OCT   = slem_pkg::REINIT_FRAMES * OCTETS_PER_FRAME
                            + slem_pkg::REINIT_OCTETS;
  localparam int RE_EDGES = (2 * RE_OCT + OCTETS_PER_PCLK - 1)
                            / OCTETS_PER_PCLK;

  if (LANES != 8 || OCTETS_PER_FRAME < 1 || OCTETS_PER_PCLK < 1
      || RE_EDGES > 255)
  begin : g_chk
    $error("slem_monitor: unsupported parameters");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] link_ctl_q;
  logic [7:0] pulse_ctl_q;
  logic [7:0] cnt_sel_q;
  logic [7:0] mode_q;
  logic [2:0] irq_en_q;
  logic [2:0] mask_q;
  logic [7:0] limit_q;
  logic [7:0] rdata_q;
  logic       link_sel;
  logic       tm_en;
  logic       ilas_test;

  assign link_sel  = link_ctl_q[slem_pkg::LINK_SEL_BIT]
                     & link_ctl_q[slem_pkg::DUAL_BIT]; // R3
  assign tm_en     = mode_q[slem_pkg::TM_EN_BIT];
  assign ilas_test = mode_q[slem_pkg::ILAS_TEST_BIT]; // R1

  function automatic logic [2:0] lane_map(input logic [2:0] x,
                                          input logic sel);
    lane_map = sel ? 3'(x + slem_pkg::LINK1_OFS) : x; // R4
  endfunction

  function automatic logic [7:0] lane_view(input logic [7:0] v,
                                           input logic sel);
    lane_view = sel ? {4'h0, v[7:4]} : v; // R3
  endfunction

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      link_ctl_q  <= slem_pkg::LINK_CTL_RST;
      pulse_ctl_q <= slem_pkg::PULSE_CTL_RST;
      cnt_sel_q   <= slem_pkg::ZERO8;
      mode_q      <= slem_pkg::ZERO8;
      irq_en_q    <= 3'h0;
      mask_q      <= 3'h0;
      limit_q     <= slem_pkg::LIMIT_RST;
    end
    else if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        slem_pkg::OFF_LINK_CTL:  link_ctl_q  <= reg_wdata_in;
        slem_pkg::OFF_PULSE_CTL: pulse_ctl_q <= reg_wdata_in;
        slem_pkg::OFF_CNT_SEL:   cnt_sel_q   <= reg_wdata_in; // R6
        slem_pkg::OFF_MODE:      mode_q      <= reg_wdata_in;
        slem_pkg::OFF_IRQ:       irq_en_q    <= reg_wdata_in[7:5];
        slem_pkg::OFF_MASK:      mask_q      <= reg_wdata_in[7:5];
        slem_pkg::OFF_LIMIT:     limit_q     <= reg_wdata_in;
        default:                 ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Processing clock edge finder
  // ---------------------------------------------------------------
  logic [2:0] pclk_q;
  logic       pedge;

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      pclk_q <= 3'h0;
    else
      pclk_q <= {pclk_q[1:0], processing_clock_in};
  end
  assign pedge = pclk_q[2] ^ pclk_q[1];

  // ---------------------------------------------------------------
  // Error counters, status and interrupt flags
  // ---------------------------------------------------------------
  slem_pkg::slem_state_t state_q;
  logic [2:0][LANES-1:0] err_v;
  logic [2:0][LANES-1:0] over;
  logic [2:0][LANES-1:0] over_q;
  logic [2:0][LANES-1:0] irq_q;
  logic [2:0][LANES-1:0] dis_q;
  logic [7:0]            cnt_q [3][LANES];
  logic [2:0]            ctl_wr;
  logic [2:0]            ctl_lane;
  logic [2:0]            sat_en;
  logic                  clr_all;

  assign err_v[0] = disp_err_in;                       // R5
  assign err_v[1] = table_miss_in;                     // R5
  assign err_v[2] = ctrl_char_err_in & {LANES{~ilas_test}}; // R1 R5
  assign ctl_lane = lane_map(reg_wdata_in[2:0], link_sel);
  assign clr_all  = state_q == slem_pkg::ST_REINIT;    // R21

  for (genvar t = 0; t < 3; t++)
  begin : g_type
    assign ctl_wr[t] = reg_wr_in
                       && reg_addr_in == 12'(slem_pkg::OFF_DISP_CTL + t);
    assign sat_en[t] = ~tm_en | mask_q[slem_pkg::TYPE_HI_BIT - 5 - t];
    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
      logic hit;
      assign hit = ctl_wr[t] && ctl_lane == 3'(l);
      assign over[t][l] = limit_q != slem_pkg::ZERO8
                          && cnt_q[t][l] >= limit_q; // R9 R12

      always_ff @(posedge mclk_in)
      begin
        if (sys_rst_in || clr_all)
          cnt_q[t][l] <= slem_pkg::ZERO8; // R21
        else if (hit && reg_wdata_in[slem_pkg::CLR_CNT_BIT])
          cnt_q[t][l] <= slem_pkg::ZERO8; // R11
        else if (err_v[t][l] && !dis_q[t][l]
                 && (!sat_en[t] || cnt_q[t][l] < limit_q)) // R8 R18
          cnt_q[t][l] <= cnt_q[t][l] + 8'h01; // R24
      end

      always_ff @(posedge mclk_in)
      begin
        if (sys_rst_in)
          dis_q[t][l] <= 1'b0;
        else if (hit)
          dis_q[t][l] <= reg_wdata_in[slem_pkg::DIS_BIT]; // R11
      end

      always_ff @(posedge mclk_in)
      begin
        if (sys_rst_in)
        begin
          over_q[t][l] <= 1'b0;
          irq_q[t][l]  <= 1'b0;
        end
        else
        begin
          over_q[t][l] <= over[t][l];
          if (over[t][l] && !over_q[t][l])
            irq_q[t][l] <= 1'b1; // R15
          else if (hit && reg_wdata_in[slem_pkg::CLR_IRQ_BIT])
            irq_q[t][l] <= 1'b0; // R10
        end
      end

      property p_sat;
        @(posedge mclk_in) disable iff (sys_rst_in)
        sat_en[t] && cnt_q[t][l] >= limit_q && !clr_all
        |=> cnt_q[t][l] <= $past(cnt_q[t][l]);
      endproperty
      a_sat: assert property (p_sat) // R8
        else $error("counter passed the limit");

      property p_disable;
        @(posedge mclk_in) disable iff (sys_rst_in)
        dis_q[t][l] && !clr_all && !ctl_wr[t] |=> $stable(cnt_q[t][l]);
      endproperty
      a_disable: assert property (p_disable) // R11
        else $error("disabled counter moved");

      property p_irq_set;
        @(posedge mclk_in) disable iff (sys_rst_in)
        over[t][l] && !over_q[t][l] |=> irq_q[t][l];
      endproperty
      a_irq_set: assert property (p_irq_set) // R15
        else $error("interrupt flag not set");
    end
  end

  // ---------------------------------------------------------------
  // Lane synchronization tracking
  // ---------------------------------------------------------------
  logic [2:0] kcnt_q  [LANES];
  logic [2:0] dcnt_q  [LANES];
  logic [LANES-1:0] cgs_done;
  logic [LANES-1:0] disp4;
  logic [LANES-1:0] aligned_q;

  for (genvar l = 0; l < LANES; l++)
  begin : g_sync
    assign cgs_done[l] = kcnt_q[l] == slem_pkg::CGS_NEED;
    assign disp4[l]    = dcnt_q[l] == slem_pkg::DISP_REINIT;
    always_ff @(posedge mclk_in)
    begin
      if (sys_rst_in || clr_all
          || !link_ctl_q[slem_pkg::LINK_EN_BIT])
        kcnt_q[l] <= 3'h0;
      else if (k_char_in[l] && !cgs_done[l])
        kcnt_q[l] <= kcnt_q[l] + 3'h1; // R2
    end
    always_ff @(posedge mclk_in)
    begin
      if (sys_rst_in || state_q != slem_pkg::ST_RUN)
        dcnt_q[l] <= 3'h0;
      else if (disp_err_in[l] && !disp4[l])
        dcnt_q[l] <= dcnt_q[l] + 3'h1; // R16
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      aligned_q <= '0;
    else
      aligned_q <= lane_aligned_in & lane_enable_in; // R23
  end

  // ---------------------------------------------------------------
  // Link state and sync request
  // ---------------------------------------------------------------
  logic       cgs_all;
  logic       err_any;
  logic       trig;
  logic [7:0] re_q;
  logic [2:0] pul_q;
  logic [2:0] pw;
  logic       sync_q;

  assign cgs_all = |lane_enable_in
                   && (cgs_done & lane_enable_in) == lane_enable_in;
  assign err_any = |(err_v[0] | err_v[1] | err_v[2]);
  assign trig    = |(disp4 & lane_enable_in)                 // R16
                   || (tm_en && |{mask_q[2] && |over[0],
                                  mask_q[1] && |over[1],
                                  mask_q[0] && |over[2]}); // R19 R20
  always_comb
  begin
    unique case (pulse_ctl_q[slem_pkg::PW_LSB +: 2])
      2'h0:    pw = 3'h1;
      2'h1:    pw = 3'h2;
      default: pw = 3'h4;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= slem_pkg::ST_CGS;
      re_q    <= slem_pkg::ZERO8;
    end
    else
    begin
      unique case (state_q)
        slem_pkg::ST_CGS:
          if (link_ctl_q[slem_pkg::LINK_EN_BIT] && cgs_all)
            state_q <= slem_pkg::ST_RUN; // R2
        slem_pkg::ST_RUN:
          if (!link_ctl_q[slem_pkg::LINK_EN_BIT])
            state_q <= slem_pkg::ST_CGS;
          else if (trig)
          begin
            state_q <= slem_pkg::ST_REINIT;
            re_q    <= 8'(RE_EDGES); // R17
          end
        slem_pkg::ST_REINIT:
          if (re_q == slem_pkg::ZERO8)
            state_q <= slem_pkg::ST_CGS;
          else if (pedge)
            re_q <= re_q - 8'h01; // R17
        default:
          state_q <= slem_pkg::ST_CGS;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || state_q != slem_pkg::ST_RUN)
      pul_q <= 3'h0;
    else if (pul_q == 3'h0 && err_any && !trig)
      pul_q <= pw; // R13
    else if (pul_q != 3'h0 && pedge)
      pul_q <= pul_q - 3'h1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      sync_q <= 1'b0;
    else
      sync_q <= state_q == slem_pkg::ST_RUN && pul_q == 3'h0; // R25
  end
  assign sync_request_out = sync_q;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [2:0] sel_lane;
  logic [7:0] sel_cnt;
  logic [2:0] irq_any;

  assign sel_lane = lane_map(cnt_sel_q[slem_pkg::CNT_LANE_LSB +: 3],
                             link_sel); // R4
  assign sel_cnt  = cnt_sel_q[1:0] == slem_pkg::TYPE_DISP
                    ? cnt_q[0][sel_lane]
                    : cnt_sel_q[1:0] == slem_pkg::TYPE_TBL
                    ? cnt_q[1][sel_lane]
                    : cnt_sel_q[1:0] == slem_pkg::TYPE_CCH
                    ? cnt_q[2][sel_lane] : slem_pkg::ZERO8; // R7
  assign irq_any  = {|irq_q[0], |irq_q[1], |irq_q[2]} & irq_en_q;

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      rdata_q <= slem_pkg::ZERO8;
    else if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        slem_pkg::OFF_LINK_CTL:  rdata_q <= link_ctl_q;
        slem_pkg::OFF_PULSE_CTL: rdata_q <= pulse_ctl_q;
        slem_pkg::OFF_CNT_SEL:   rdata_q <= sel_cnt; // R6
        slem_pkg::OFF_DISP_CTL:  rdata_q <= lane_view(over[0], link_sel);
        slem_pkg::OFF_TBL_CTL:   rdata_q <= lane_view(over[1], link_sel);
        slem_pkg::OFF_CCH_CTL:   rdata_q <= lane_view(over[2], link_sel);
        slem_pkg::OFF_CGS_STAT:  rdata_q <= lane_view(cgs_done, link_sel);
        slem_pkg::OFF_ALIGN_ST:  rdata_q <= lane_view(aligned_q, link_sel);
        slem_pkg::OFF_MODE:      rdata_q <= mode_q;
        slem_pkg::OFF_IRQ:       rdata_q <= {irq_any, 5'h00}; // R15
        slem_pkg::OFF_MASK:      rdata_q <= {mask_q, 5'h00};
        slem_pkg::OFF_LIMIT:     rdata_q <= limit_q;
        default:                 rdata_q <= slem_pkg::ZERO8;
      endcase
    end
    else
      rdata_q <= slem_pkg::ZERO8;
  end
  assign reg_rdata_out = rdata_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_err_start;
    state_q == slem_pkg::ST_RUN && pul_q == 3'h0 && err_any && !trig
    && link_ctl_q[slem_pkg::LINK_EN_BIT];
  endsequence
  sequence s_low_pulse;
    pul_q != 3'h0 ##1 !sync_request_out;
  endsequence

  property p_err_pulse;
    s_err_start |=> s_low_pulse;
  endproperty
  a_err_pulse: assert property (p_err_pulse) // R13
    else $error("error did not pulse sync low");

  property p_cgs_release;
    state_q == slem_pkg::ST_CGS && cgs_all
    && link_ctl_q[slem_pkg::LINK_EN_BIT] |=> ##1 sync_request_out
    || !(state_q == slem_pkg::ST_RUN);
  endproperty
  a_cgs_release: assert property (p_cgs_release) // R2
    else $error("sync not released after CGS");

  property p_cgs_low;
    state_q == slem_pkg::ST_CGS |=> !sync_request_out;
  endproperty
  a_cgs_low: assert property (p_cgs_low) // R25
    else $error("sync high during CGS");

  property p_reinit;
    state_q == slem_pkg::ST_RUN && trig
    && link_ctl_q[slem_pkg::LINK_EN_BIT]
    |=> state_q == slem_pkg::ST_REINIT && re_q == 8'(RE_EDGES)
        ##1 !sync_request_out;
  endproperty
  a_reinit: assert property (p_reinit) // R16
    else $error("reinit not requested");

  property p_reinit_clr;
    state_q == slem_pkg::ST_REINIT |=> cnt_q[0][0] == slem_pkg::ZERO8
                                     && cnt_q[2][7] == slem_pkg::ZERO8;
  endproperty
  a_reinit_clr: assert property (p_reinit_clr) // R21
    else $error("counters not cleared by reinit");

  property p_cnt_read;
    reg_rd_in && reg_addr_in == slem_pkg::OFF_CNT_SEL
    |=> reg_rdata_out == $past(sel_cnt);
  endproperty
  a_cnt_read: assert property (p_cnt_read) // R6
    else $error("count readback wrong");
endmodule
`default_nettype wire

// ### testbench/slem_tx_model.sv
// Far-side transmitter model: K characters, errors, processing clock
`timescale 1ns/1ps
`default_nettype none
module slem_tx_model (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  // Requests from the bench, and the sync request from the monitor
  input  wire logic       send_k_in,
  input  wire logic [2:0] err_kind_in,
  input  wire logic [2:0] err_lane_in,
  input  wire logic       err_go_in,
  input  wire logic       sync_request_in,
  // Lane side
  output logic      [7:0] k_char_out,
  output logic      [7:0] disp_err_out,
  output logic      [7:0] table_miss_out,
  output logic      [7:0] ctrl_char_err_out,
  output logic      [7:0] lane_aligned_out,
  output logic            pclk_out
);
  logic [1:0] div_q;

  function automatic logic [7:0] hit(input int b);
    return (err_go_in && err_kind_in[b]) ? 8'h01 << err_lane_in : 8'h00;
  endfunction

  // Free-running processing clock, 80 ns, phase unrelated to mclk
  initial
  begin
    pclk_out = 1'b0;
    #3;
    forever #40 pclk_out = ~pclk_out;
  end

  always_ff @(posedge mclk_in)
  begin
    div_q <= sys_rst_in ? 2'h0 : div_q + 2'h1;
    k_char_out <= {8{send_k_in && div_q == 2'h0}};
    lane_aligned_out <= sys_rst_in ? 8'h00 :
                        {8{sync_request_in && !send_k_in}};
    disp_err_out <= hit(0);
    table_miss_out <= hit(1);
    ctrl_char_err_out <= hit(2);
  end
endmodule
`default_nettype wire

// ### testbench/slem_monitor_tb.sv
// Self-checking bench for the serial link error monitor
`timescale 1ns/1ps
`default_nettype none
module slem_monitor_tb;
  logic        mclk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [11:0] reg_addr_in = 12'h000;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [7:0]  reg_rdata_out, k_char, disp_err, tbl_err, cch_err, aligned;
  logic        pclk, sync_request_out, rd_d = 1'b0;
  logic        send_k = 1'b0;
  logic        err_go = 1'b0;
  logic [2:0]  err_kind = 3'h0;
  logic [2:0]  err_lane = 3'h0;
  logic [7:0]  exp_q[$];
  logic [31:0] rs = 32'h535A;
  logic [2:0]  ln[3];
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          w;

  always #4 mclk_in = ~mclk_in;

  slem_monitor uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .disp_err_in(disp_err),
    .table_miss_in(tbl_err), .ctrl_char_err_in(cch_err),
    .k_char_in(k_char), .lane_aligned_in(aligned),
    .lane_enable_in(8'hFF), .processing_clock_in(pclk),
    .sync_request_out(sync_request_out));

  slem_tx_model tx (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .send_k_in(send_k), .err_kind_in(err_kind), .err_lane_in(err_lane),
    .err_go_in(err_go), .sync_request_in(sync_request_out),
    .k_char_out(k_char), .disp_err_out(disp_err),
    .table_miss_out(tbl_err), .ctrl_char_err_out(cch_err),
    .lane_aligned_out(aligned), .pclk_out(pclk));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    exp_q.push_back(e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
  endtask

  task automatic cnt(input logic [2:0] l, input logic [1:0] t,
                     input logic [7:0] e);
    wr(slem_pkg::OFF_CNT_SEL, {1'b0, l, 2'h0, t});
    rd(slem_pkg::OFF_CNT_SEL, e);
  endtask

  task automatic err(input logic [1:0] t, input logic [2:0] l);
    @(posedge mclk_in);
    err_kind <= 3'h1 << t;
    err_lane <= l;
    err_go <= 1'b1;
    @(posedge mclk_in);
    err_go <= 1'b0;
    repeat (3) @(posedge mclk_in);
  endtask

  task automatic low_for(input int n);
    w = 0;
    repeat (n) @(posedge mclk_in) w += int'(sync_request_out === 1'b0);
  endtask

  task automatic wait_hi;
    for (int i = 0; i < 300 && sync_request_out !== 1'b1; i++)
      @(posedge mclk_in);
    chk({7'h00, sync_request_out}, 8'h01);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Read data checker and cycle limit
  always @(posedge mclk_in)
  begin
    rd_d <= reg_rd_in;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done;
    end
  end

  always @(negedge mclk_in)
    if (rd_d)
      chk(reg_rdata_out, exp_q.pop_front());

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(slem_pkg::OFF_LIMIT, 8'hFF);
    rd(slem_pkg::OFF_MASK, 8'h00);
    rd(12'h123, 8'h00);
    chk({7'h00, sync_request_out}, 8'h00);
    wr(slem_pkg::OFF_MODE, 8'h80);
    send_k <= 1'b1;
    wr(slem_pkg::OFF_LINK_CTL, 8'h01);
    wait_hi;
    send_k <= 1'b0;
    repeat (4) @(posedge mclk_in);
    rd(slem_pkg::OFF_ALIGN_ST, 8'hFF);
    err(2'h2, 3'h1);
    cnt(3'h1, 2'h2, 8'h00);
    wr(slem_pkg::OFF_MODE, 8'h00);
    wr(slem_pkg::OFF_LIMIT, 8'h03);
    for (int t = 0; t < 3; t++)
    begin
      rs = xs(rs);
      ln[t] = rs[2:0];
      repeat (t == 0 ? 2 : 5) err(t[1:0], ln[t]);
      cnt(ln[t], t[1:0], t == 0 ? 8'h02 : 8'h03);
      rd(slem_pkg::OFF_DISP_CTL + 12'(t),
         t == 0 ? 8'h00 : 8'h01 << ln[t]);
    end
    wr(slem_pkg::OFF_IRQ, 8'hE0);
    rd(slem_pkg::OFF_IRQ, 8'h60);
    wr(slem_pkg::OFF_CCH_CTL, 8'h80 | {5'h00, ln[2]});
    rd(slem_pkg::OFF_IRQ, 8'h40);
    wr(slem_pkg::OFF_CCH_CTL, 8'h20 | {5'h00, ln[2]});
    cnt(ln[2], 2'h2, 8'h00);
    wr(slem_pkg::OFF_CCH_CTL, 8'h40 | {5'h00, ln[2]});
    err(2'h2, ln[2]);
    cnt(ln[2], 2'h2, 8'h00);
    wr(slem_pkg::OFF_CCH_CTL, {5'h00, ln[2]});
    for (int p = 0; p < 3; p++)
    begin
      wr(slem_pkg::OFF_PULSE_CTL, {2'h0, p[1:0], 4'h0});
      repeat (40) @(posedge mclk_in);
      fork
        err(2'h1, ln[1]);
        low_for(60);
      join
      chk({7'h00, w >= 5 * (1 << p) - 4 && w <= 5 * (1 << p)},
          8'h01);
    end
    repeat (40) @(posedge mclk_in);
    send_k <= 1'b1;
    fork
      begin
        err(2'h0, ln[0]);
        err(2'h0, ln[0]);
      end
      low_for(150);
    join
    chk({7'h00, w >= 40 && w <= 120}, 8'h01);
    wait_hi;
    send_k <= 1'b0;
    cnt(ln[1], 2'h1, 8'h00);
    rd(slem_pkg::OFF_IRQ, 8'hC0);
    wr(slem_pkg::OFF_LINK_CTL, 8'h0D);
    err(2'h1, 3'h6);
    cnt(3'h2, 2'h1, 8'h01);
    wr(slem_pkg::OFF_MODE, 8'h08);
    wr(slem_pkg::OFF_MASK, 8'h40);
    rd(slem_pkg::OFF_MASK, 8'h40);
    send_k <= 1'b1;
    fork
      repeat (3) err(2'h1, 3'h1);
      low_for(150);
    join
    chk({7'h00, w >= 40 && w <= 120}, 8'h01);
    wait_hi;
    send_k <= 1'b0;
    repeat (4) err(2'h2, 3'h4);
    cnt(3'h0, 2'h2, 8'h04);
    repeat (10) @(posedge mclk_in);
    test_done;
  end
endmodule
`default_nettype wire
